// file: lsp_defines.svh
/*
  constants of the channel 3/4 set-point frame block: frame layout,
  selector codes, register offsets, field positions and reset values.
  assumes it is included by its bare name, once per compilation unit.
*/
`ifndef LSP_DEFINES_SVH
`define LSP_DEFINES_SVH

// frame layout
`define LSP_FRAME_W 16
`define LSP_PAR_BIT 15
`define LSP_SEL_HI 14
`define LSP_SEL_LO 10
`define LSP_SEL_CH3 5'h0C
`define LSP_SEL_CH4 5'h0D

// register offsets (byte addresses)
`define LSP_ADDR_CTRL 8'h00
`define LSP_ADDR_STATUS 8'h04
`define LSP_ADDR_SETPT3 8'h08
`define LSP_ADDR_SETPT4 8'h0C

// control fields and reset values
`define LSP_CTRL_REGOFF 0
`define LSP_CTRL_FB 1
`define LSP_CTRL_RST 2'h0
`define LSP_TARGET_RST 10'h000
`define LSP_DUTY_RST 8'h00
`define LSP_TX_RST 16'h0000

`endif

// file: lsp_pkg.sv
/*
  types of the channel 3/4 set-point frame block.
  assumes nothing of its surroundings.
*/
package lsp_pkg;

  // one-hot steps of the frame handling pipeline
  typedef enum logic [2:0] {
    st_idle = 3'h1,
    st_dec = 3'h2,
    st_build = 3'h4
  } lsp_state_t;

  typedef logic [15:0] lsp_frame_t;

endpackage

// file: lsp_ch34_setpoint.sv
/*
  serial frame decoder and responder for the set points of valve drivers
  3 and 4, with an apb slave for control and status.
  assumes: link in mode with sclk idle low, device drives miso on rising
  sclk and samples mosi on falling sclk, msb first, 16 bits per cs_n low;
  sclk runs only inside frames; the gap between frames is at least
  eight clk cycles; status inputs come from logic on clk.
  register map, one 32-bit word each, reached over apb:
    0x00 control: bit 0 regulation off, bit 1 readback select
    0x04 status: bit 0 parity error of the last frame, bits 15:8 frame count
    0x08 channel 3 set points: bits 9:0 target, bits 23:16 duty, read only
    0x0c channel 4 set points, same layout, read only
  apb answers with one wait state; an unknown address gives pslverr.
  each response carries the answer to the frame before it: the answer is
  built a few clk cycles after a frame ends, with the control bits and
  channel status as they stand then, and waits for the next frame.
  a frame cut short by cs_n is dropped and leaves no trace.
//
// Contract
// - selector 01100 in bits 14:10 addresses channel 3; parity bit 15, payload 9:0.
// - selector 01101 addresses channel 4 with the same layout.
// - regulation on: store payload 9:0 as 10-bit current target.
// - regulation off: channel 3 takes duty in bits 9:2, bits 1:0 ignored.
// - regulation off: channel 4 takes duty in bits 9:2, bits 1:0 ignored.
// - response bit 14 is 1 when the previous frame had bad parity.
// - channel 4 response bit 13 reports overcurrent shutdown.
// - channel 4 response bit 12 reports open load.
// - channel 4 response bit 11 reports overtemperature shutdown.
// - channel 4 response bit 10 reports drain voltage detection, informative.
// - channel 3 response bits 14:10: parity flag, oc, open, ot, drain flags.
// - regulation on, readback 0: payload echoes stored current target.
// - regulation on, readback 1: payload returns regulator duty in bits 9:2.
// - regulation off, readback 0: duty in bits 9:2, bits 1:0 zero.
// - regulation off, readback 1: payload returns measured 10-bit current.
*/
`timescale 1ns/1ps
`include "lsp_defines.svh"

module lsp_ch34_setpoint #(
  parameter bit PAR_ODD = 1'b1 // 1: odd parity over all 16 bits
) (
  input wire logic clk, // system clock
  input wire logic reset, // async reset, active high
  // apb slave
  input wire logic psel, // slave select
  input wire logic penable, // access phase
  input wire logic pwrite, // 1 write, 0 read
  input wire logic [7:0] paddr, // byte address
  input wire logic [31:0] pwdata, // write data
  output logic [31:0] prdata, // read data
  output logic pready, // transfer done
  output logic pslverr, // unmapped address
  // serial link
  input wire logic sclk, // link clock from master
  input wire logic cs_n, // frame select, active low
  input wire logic mosi, // data from master
  output logic miso, // data to master
  output logic miso_oe, // miso drive enable
  // channel status from the drivers
  input wire logic ch3_overcurrent_flag, // oc shutdown ch3
  input wire logic ch3_open_load_flag, // open load ch3
  input wire logic ch3_overtemp_flag, // ot shutdown ch3
  input wire logic ch3_drain_voltage_flag, // vds seen ch3
  input wire logic ch4_overcurrent_flag, // oc shutdown ch4
  input wire logic ch4_open_load_flag, // open load ch4
  input wire logic ch4_overtemp_flag, // ot shutdown ch4
  input wire logic ch4_drain_voltage_flag, // vds seen ch4
  input wire logic [7:0] ch3_reg_duty, // regulator duty ch3
  input wire logic [7:0] ch4_reg_duty, // regulator duty ch4
  input wire logic [9:0] ch3_current, // measured current ch3
  input wire logic [9:0] ch4_current, // measured current ch4
  // set points and mode to the drivers
  output logic [9:0] ch3_target, // current target ch3
  output logic [7:0] ch3_duty, // pwm duty ch3
  output logic [9:0] ch4_target, // current target ch4
  output logic [7:0] ch4_duty, // pwm duty ch4
  output logic regulation_off_ch34, // 1: pwm mode
  output logic readback_select // response payload choice
);
  import lsp_pkg::*;

  // payload of a response, chosen by mode and readback select
  // duty values sit in bits 9:2 so the master reads them the way it writes them
  function automatic logic [9:0] rsp_payload(
    input logic off,
    input logic fb,
    input logic [9:0] tgt,
    input logic [7:0] dty,
    input logic [7:0] rdty,
    input logic [9:0] cur
  );
    logic [9:0] p;
    p = 10'h000;
    case ({off, fb})
      2'b00: p = tgt;
      2'b01: p = {rdty, 2'b00};
      2'b10: p = {dty, 2'b00};
      2'b11: p = cur;
      default: p = 10'h000;
    endcase
    return p;
  endfunction

  // which of the two set-point messages a selector names: {ch4, ch3}
  function automatic logic [1:0] sel_decode(input logic [4:0] sel);
    logic [1:0] h;
    h = 2'b00;
    if (sel == `LSP_SEL_CH3) begin
      h = 2'b01;
    end else if (sel == `LSP_SEL_CH4) begin
      h = 2'b10;
    end
    return h;
  endfunction

  // ---- link domain, clocked by sclk ----
  logic [3:0] bit_cnt_q;
  logic [14:0] rx_sh_q;
  lsp_frame_t rx_word_q;
  logic rx_tgl_q;
  logic miso_q;
  logic miso_oe_q;
  lsp_frame_t tx_word_q;
  lsp_frame_t tx_cap_q;

  // cs_n high ends any frame at once; partial frames are dropped
  // an aborted frame thus leaves no half-shifted word behind
  wire link_rst = reset | cs_n;
  wire frame_last = (bit_cnt_q == 4'hF);
  wire [3:0] tx_idx = 4'hF - bit_cnt_q;

  // the answer word is read from the clk side once, at the first rising edge,
  // so a late change there cannot tear a frame in flight
  wire frame_first = ~miso_oe_q;
  wire [15:0] tx_src = frame_first ? tx_word_q : tx_cap_q;

  // sample mosi on the falling edge, msb first
  always_ff @(negedge sclk or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_q <= 4'h0;
      rx_sh_q <= 15'h0000;
    end else begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
      rx_sh_q <= {rx_sh_q[13:0], mosi};
    end
  end

  // hand a whole frame over with a toggle event
  // a toggle, unlike a pulse, survives the crossing whatever the clock ratio
  always_ff @(negedge sclk or posedge reset) begin
    if (reset) begin
      rx_word_q <= 16'h0000;
      rx_tgl_q <= 1'b0;
    end else if (frame_last) begin
      rx_word_q <= {rx_sh_q, mosi};
      rx_tgl_q <= ~rx_tgl_q;
    end
  end

  // hold the answer taken at the first rising edge for the rest of the frame
  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      tx_cap_q <= `LSP_TX_RST;
    end else if (frame_first) begin
      tx_cap_q <= tx_word_q;
    end
  end

  // drive the prepared answer out on the rising edge
  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      miso_q <= 1'b0;
      miso_oe_q <= 1'b0;
    end else begin
      miso_q <= tx_src[tx_idx];
      miso_oe_q <= 1'b1;
    end
  end

  // ---- system domain, clocked by clk ----
  logic tgl_s1_q;
  logic tgl_s2_q;
  logic tgl_s3_q;
  lsp_state_t state_q;
  lsp_state_t state_d;
  lsp_frame_t rx_hold_q;
  logic perr_q;
  logic [4:0] sel_q;
  logic [7:0] frame_cnt_q;
  logic [1:0] ctrl_q;
  logic [9:0] target_q [2];
  logic [7:0] duty_q [2];
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // toggle synchroniser; only the second stage is looked at
  // the third flop only remembers the old level for the edge detect
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
    end else begin
      tgl_s1_q <= rx_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
    end
  end

  wire frame_new = tgl_s2_q ^ tgl_s3_q;

  // step order: take word, decode and store, build answer
  // building after the store lets the answer echo the value just written
  always_comb begin
    state_d = state_q;
    case (state_q)
      st_idle: state_d = frame_new ? st_dec : st_idle;
      st_dec: state_d = st_build;
      st_build: state_d = st_idle;
      default: state_d = st_idle;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= st_idle;
    end else begin
      state_q <= state_d;
    end
  end

  // rx_word_q is stable here: the next frame is 16 sclk edges away
  // taking a copy frees the link to start shifting the next frame
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_hold_q <= 16'h0000;
    end else if (state_q == st_idle && frame_new) begin
      rx_hold_q <= rx_word_q;
    end
  end

  // frame decode
  wire in_dec = (state_q == st_dec);
  wire [4:0] rx_sel = rx_hold_q[`LSP_SEL_HI:`LSP_SEL_LO];
  wire par_ok = ((^rx_hold_q) == PAR_ODD);
  wire [1:0] rx_hit = sel_decode(rx_sel);
  wire hit3 = rx_hit[0];
  wire hit4 = rx_hit[1];
  wire reg_off = ctrl_q[`LSP_CTRL_REGOFF];
  wire fb_sel = ctrl_q[`LSP_CTRL_FB];
  wire [1:0] ch_hit = {hit4, hit3};

  // parity flag of the last frame, selector of the last frame
  // the flag is replaced by every whole frame, it does not stick
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      perr_q <= 1'b0;
      sel_q <= 5'h00;
      frame_cnt_q <= 8'h00;
    end else if (in_dec) begin
      perr_q <= ~par_ok;
      sel_q <= rx_sel;
      frame_cnt_q <= frame_cnt_q + 8'h01;
    end
  end

  // per-channel set-point stores
  // a failed parity check leaves both stores alone; the flag tells the master
  for (genvar i = 0; i < 2; i++) begin : g_ch
    wire wr_ok = in_dec & par_ok & ch_hit[i];
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        target_q[i] <= `LSP_TARGET_RST;
        duty_q[i] <= `LSP_DUTY_RST;
      end else if (wr_ok && !reg_off) begin
        target_q[i] <= rx_hold_q[9:0];
      end else if (wr_ok && reg_off) begin
        duty_q[i] <= rx_hold_q[9:2];
      end
    end
  end

  // response fields per channel
  // flags and payload are sampled when the answer is built, not when it is sent
  wire [3:0] flags3 = {ch3_overcurrent_flag, ch3_open_load_flag,
                       ch3_overtemp_flag, ch3_drain_voltage_flag};
  wire [3:0] flags4 = {ch4_overcurrent_flag,
                       ch4_open_load_flag,
                       ch4_overtemp_flag,
                       ch4_drain_voltage_flag};
  wire [9:0] pay3 = rsp_payload(reg_off, fb_sel, target_q[0], duty_q[0],
                                ch3_reg_duty, ch3_current);
  wire [9:0] pay4 = rsp_payload(reg_off, fb_sel, target_q[1], duty_q[1],
                                ch4_reg_duty, ch4_current);
  wire [1:0] last_hit = sel_decode(sel_q);
  wire last3 = last_hit[0];
  wire last4 = last_hit[1];
  wire [13:0] body3 = {flags3, pay3};
  wire [13:0] body4 = {flags4, pay4};
  wire [13:0] body_ch = last3 ? body3 : (last4 ? body4 : 14'h0000);
  wire [14:0] tx_body = {perr_q, body_ch};
  wire tx_par = (^tx_body) ^ PAR_ODD;
  wire [15:0] tx_next = {tx_par, tx_body};

  // answer for the next frame; read by the link only at a frame's first edge
  // it is built while the link is idle, so the word is settled before use
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_word_q <= `LSP_TX_RST;
    end else if (state_q == st_build) begin
      tx_word_q <= tx_next;
    end
  end

  // ---- apb slave ----
  // writes to read-only words are taken and ignored, without an error
  wire a_ctrl = (paddr == `LSP_ADDR_CTRL);
  wire a_stat = (paddr == `LSP_ADDR_STATUS);
  wire a_sp3 = (paddr == `LSP_ADDR_SETPT3);
  wire a_sp4 = (paddr == `LSP_ADDR_SETPT4);
  wire mapped = a_ctrl | a_stat | a_sp3 | a_sp4;
  wire acc = psel & penable & ~pready_q;
  wire done = psel & penable & pready_q;
  wire ctrl_wr = done & pwrite & a_ctrl;
  wire [31:0] rd_ctrl = {30'h0000_0000, ctrl_q};
  wire [31:0] rd_stat = {16'h0000, frame_cnt_q, 7'h00, perr_q};
  wire [31:0] rd_sp3 = {8'h00, duty_q[0], 6'h00, target_q[0]};
  wire [31:0] rd_sp4 = {8'h00, duty_q[1], 6'h00, target_q[1]};
  wire [31:0] rd_mux = a_ctrl ? rd_ctrl :
                       a_stat ? rd_stat :
                       a_sp3 ? rd_sp3 :
                       a_sp4 ? rd_sp4 : 32'h0000_0000;

  // control register, written at the completing edge
  // a new mode applies to the next frame decoded and the next answer built
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= `LSP_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_q <= pwdata[1:0];
    end
  end

  // one wait state, then ready with data or error
  // read data is zero outside the answering cycle, so nothing stale shows
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= acc;
      pslverr_q <= acc & ~mapped;
      prdata_q <= (acc & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // outputs
  // every output comes from a flop, none from combinational logic
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign miso = miso_q;
  assign miso_oe = miso_oe_q;
  assign ch3_target = target_q[0];
  assign ch3_duty = duty_q[0];
  assign ch4_target = target_q[1];
  assign ch4_duty = duty_q[1];
  assign regulation_off_ch34 = ctrl_q[`LSP_CTRL_REGOFF];
  assign readback_select = ctrl_q[`LSP_CTRL_FB];

endmodule

// file: lsp_ch34_props.sv
/* port assertions for the set-point block.
   assumes it is bound to lsp_ch34_setpoint. */
`timescale 1ns/1ps
module lsp_ch34_props (
  input wire logic clk, // clock
  input wire logic reset, // reset
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pready, // ready
  input wire logic sclk, // link clock
  input wire logic cs_n, // frame select
  input wire logic miso, // data out
  input wire logic miso_oe, // drive
  input wire logic [9:0] ch3_target, // target 3
  input wire logic [7:0] ch3_duty, // duty 3
  input wire logic [9:0] ch4_target, // target 4
  input wire logic [7:0] ch4_duty, // duty 4
  input wire logic regulation_off_ch34 // mode
);
  logic [7:0] gap_q;
  // clk cycles since the frame select went high
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      gap_q <= 8'hff;
    else if (!cs_n)
      gap_q <= 8'h00;
    else if (gap_q != 8'hff)
      gap_q <= gap_q + 8'h01;
  end
  a_ready_follows: assert property (@(posedge clk) disable iff (reset)
    psel && penable && !pready |=> pready) else $error("pready late");
  a_duty_kept_on: assert property (@(posedge clk) disable iff (reset)
    !regulation_off_ch34 ##1 !regulation_off_ch34 |-> $stable({ch3_duty, ch4_duty}))
    else $error("duty moved");
  a_target3_kept: assert property (@(posedge clk) disable iff (reset)
    regulation_off_ch34 ##1 regulation_off_ch34 |-> $stable(ch3_target))
    else $error("ch3 target moved");
  a_target4_kept: assert property (@(posedge clk) disable iff (reset)
    regulation_off_ch34 ##1 regulation_off_ch34 |-> $stable(ch4_target))
    else $error("ch4 target moved");
  a_store3_timed: assert property (@(posedge clk) disable iff (reset)
    !$stable({ch3_target, ch3_duty}) |-> gap_q < 8'd16) else $error("ch3 stray store");
  a_store4_timed: assert property (@(posedge clk) disable iff (reset)
    !$stable({ch4_target, ch4_duty}) |-> gap_q < 8'd16) else $error("ch4 stray store");
  a_drive_frame: assert property (@(negedge sclk) disable iff (reset)
    !cs_n |-> miso_oe) else $error("miso not driven");
  a_idle_free: assert property (@(posedge clk) disable iff (reset)
    cs_n |-> !miso_oe && !miso) else $error("miso driven idle");
endmodule
bind lsp_ch34_setpoint lsp_ch34_props u_props (.clk, .reset, .psel, .penable, .pready, .sclk,
  .cs_n, .miso, .miso_oe, .ch3_target, .ch3_duty, .ch4_target, .ch4_duty, .regulation_off_ch34);

// file: lsp_spi_master.sv
/* serial master model sending set-point frames.
   assumes sclk idle low and miso valid at falling sclk. */
`timescale 1ns/1ps
module lsp_spi_master (
  output logic sclk, // link clock
  output logic cs_n, // frame select
  output logic mosi, // data out
  input wire logic miso // data in
);
  // clock stands still outside frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // odd count of ones over the whole frame, bad flips it
  function automatic logic [15:0] mk(input logic [4:0] s, input logic [9:0] p, input logic bad);
    return {~^{s, p} ^ bad, s, p};
  endfunction
  // nb bits, slow stretches each low phase, gap above 8 clk after
  task automatic xfer(input logic [15:0] tx, input int nb, input int slow, output logic [15:0] rx);
    rx = 16'h0000;
    cs_n = 1'b0;
    #24;
    for (int k = 0; k < nb; k++) begin
      mosi = tx[15 - k];
      sclk = 1'b1;
      #24;
      rx[15 - k] = miso;
      sclk = 1'b0;
      #(24 + slow);
    end
    cs_n = 1'b1;
    mosi = ~mosi; // released line shows no stale bit
    #400;
  endtask
endmodule

// file: lsp_ch34_setpoint_tb_top.sv
/* self-checking bench for the set-point block.
   assumes lsp_spi_master as link partner, apb master here. */
`timescale 1ns/1ps
`include "lsp_defines.svh"
module lsp_ch34_setpoint_tb_top;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, off = 0, fb = 0, perr = 0;
  logic [7:0] paddr = 0, ch3_reg_duty = 0, ch4_reg_duty = 0, ch3_duty, ch4_duty, d3 = 0, d4 = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, sclk, cs_n, mosi, miso, miso_oe, regulation_off_ch34, readback_select, e;
  logic [3:0] f3 = 0, f4 = 0;
  logic [9:0] ch3_current = 0, ch4_current = 0, ch3_target, ch4_target, t3 = 0, t4 = 0;
  logic [15:0] ans_q = 0;
  int fails = 0, checks = 0, nfr = 0, seed = 32'h6a2f_caa9;
  always #12.5 clk = ~clk;
  lsp_ch34_setpoint #(.PAR_ODD(1'b1)) DUT (.clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sclk, .cs_n, .mosi, .miso, .miso_oe,
    .ch3_overcurrent_flag(f3[3]), .ch3_open_load_flag(f3[2]), .ch3_overtemp_flag(f3[1]),
    .ch3_drain_voltage_flag(f3[0]), .ch4_overcurrent_flag(f4[3]), .ch4_open_load_flag(f4[2]),
    .ch4_overtemp_flag(f4[1]), .ch4_drain_voltage_flag(f4[0]), .ch3_reg_duty, .ch4_reg_duty,
    .ch3_current, .ch4_current, .ch3_target, .ch3_duty, .ch4_target, .ch4_duty,
    .regulation_off_ch34, .readback_select);
  lsp_spi_master u_m (.sclk, .cs_n, .mosi, .miso);
  // closing report
  task automatic print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // compare and count
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fails++;
      print_verdict();
    end
  endtask
  // one frame with fresh status inputs, model updated after it
  task automatic frame(input logic [4:0] s, input logic [9:0] p, input logic bad, input int nb);
    logic [15:0] rx, nx;
    logic [9:0] py;
    @(posedge clk);
    {f3, f4, ch3_reg_duty, ch4_reg_duty} <= 24'($random(seed));
    {ch3_current, ch4_current} <= 20'($random(seed));
    @(posedge clk);
    u_m.xfer(u_m.mk(s, p, bad), nb, (nfr % 2) * 30, rx);
    if (nb == 16) begin
      chk(rx, ans_q);
      nfr++;
      perr = bad;
      if (!bad && s == `LSP_SEL_CH3 && off) d3 = p[9:2];
      if (!bad && s == `LSP_SEL_CH3 && !off) t3 = p;
      if (!bad && s == `LSP_SEL_CH4 && off) d4 = p[9:2];
      if (!bad && s == `LSP_SEL_CH4 && !off) t4 = p;
      py = s[0] ? (off ? (fb ? ch4_current : {d4, 2'b00}) : (fb ? {ch4_reg_duty, 2'b00} : t4))
        : (off ? (fb ? ch3_current : {d3, 2'b00}) : (fb ? {ch3_reg_duty, 2'b00} : t3));
      nx = (s[4:1] == 4'h6) ? {1'b0, bad, s[0] ? f4 : f3, py} : {1'b0, bad, 14'h0000};
      ans_q = {~^nx[14:0], nx[14:0]};
    end
    chk({ch3_target, ch3_duty, ch4_target, ch4_duty}, {t3, d3, t4, d4});
  endtask
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    apb(1'b0, `LSP_ADDR_SETPT3, 32'h0000_0000);
    chk(q, 40'h00_0000_0000);
    #7;
    for (int m = 0; m < 4; m++) begin
      {fb, off} = 2'(m);
      apb(1'b1, `LSP_ADDR_CTRL, {30'h0000_0000, fb, off});
      @(posedge clk);
      chk({readback_select, regulation_off_ch34}, {fb, off});
      for (int i = 0; i < 6; i++)
        frame(i == 4 ? 5'h0E : 5'h0C | 5'(i % 2), i == 5 ? 10'h3FF : 10'($random(seed)), i == 2, 16);
      $display("mode %0d done", m);
    end
    frame(`LSP_SEL_CH3, 10'h155, 1'b0, 9);
    frame(`LSP_SEL_CH4, 10'h2AA, 1'b1, 16);
    apb(1'b0, `LSP_ADDR_STATUS, 32'h0000_0000);
    chk(q, {24'h00_0000, nfr[7:0], 7'h00, perr});
    apb(1'b1, `LSP_ADDR_SETPT4, 32'hFFFF_FFFF);
    apb(1'b0, `LSP_ADDR_SETPT4, 32'h0000_0000);
    chk(q, {16'h0000, d4, 6'h00, t4});
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk({e, q}, {8'h01, 32'h0000_0000});
    $display("register tests done");
    print_verdict();
  end
endmodule
